// ### dv/lgt_link_gpio_checker.sv
// Checker for the link GPIO block: register port, local I/Os, back channel.
// Bound to every lgt_link_gpio instance; sees its ports only.
`timescale 1ns/10ps
module lgt_link_gpio_checker
  import lgt_pkg::*;
(
  // Clock and reset
  input logic core_clk,
  input logic resetn,
  // Register port
  input logic regWrEn,
  input logic regRdEn,
  input logic [7:0] regAddr,
  input logic [7:0] regWrData,
  input logic [7:0] regRdData,
  // Link and back channel
  input logic fwdVideo18,
  input logic video18Mode,
  input logic bcData,
  input logic bcFrameStart,
  // Local I/Os
  input logic [3:0] localIoOut,
  input logic [3:0] localIoOe,
  input logic [3:0] audioRx
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [11:0] frameGap_q;
  logic [1:0] settle_q;
  ////////////////////////////////////////////////////////////////////////////
  // Frame spacing, ignored for two frames after reset or a rate change
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      frameGap_q <= 12'h000;
      settle_q <= 2'h2;
    end else begin
      frameGap_q <= bcFrameStart ? 12'h001 : frameGap_q + 12'(frameGap_q != 12'hFFF);
      if (regWrEn && regAddr == ADDR_BC_RATE) begin
        settle_q <= 2'h2;
      end else if (bcFrameStart && settle_q != 2'h0) begin
        settle_q <= settle_q - 2'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_cfgWr(a, d);
    regWrEn && regAddr == a && regWrData == d;
  endsequence
  sequence s_quiet;
    !(regWrEn && (regAddr == ADDR_LOC56_CFG || regAddr == ADDR_LOC78_CFG)) [*2];
  endsequence
  property p_localDrive;
    s_cfgWr(ADDR_LOC56_CFG, 8'h19) ##1 s_quiet |-> ##1 localIoOe[1:0] == 2'b11 && localIoOut[1:0] == 2'b01;
  endproperty
  property p_audioBlock;
    s_cfgWr(ADDR_LOC56_CFG, 8'h19) ##1 s_quiet |-> ##1 audioRx[1:0] == 2'b00;
  endproperty
  property p_undefOff;
    s_cfgWr(ADDR_LOC78_CFG, 8'h5F) ##1 s_quiet |-> ##1 localIoOe[3:2] == 2'b00;
  endproperty
  property p_localInput;
    s_cfgWr(ADDR_LOC78_CFG, 8'h33) ##1 s_quiet |-> ##1 localIoOe[3:2] == 2'b00 && audioRx[3:2] == 2'b00;
  endproperty
  property p_framePeriod;
    bcFrameStart && settle_q == 2'h0 |-> frameGap_q inside {12'h140, 12'h280, 12'h500};
  endproperty
  property p_rdHold;
    !$past(regRdEn) |-> $stable(regRdData);
  endproperty
  property p_highPad;
    regRdEn && regAddr == ADDR_LVL_HIGH |=> regRdData[7:1] == 7'h00;
  endproperty
  property p_video18;
    $changed(video18Mode) |-> video18Mode == fwdVideo18;
  endproperty
  property p_startBit;
    bcFrameStart |-> bcData;
  endproperty
  a_localDrive: assert property (p_localDrive) else $error("local drive levels wrong");
  a_audioBlock: assert property (p_audioBlock) else $error("audio input not overridden");
  a_undefOff: assert property (p_undefOff) else $error("undefined code drives pin");
  a_localInput: assert property (p_localInput) else $error("local input mode wrong");
  a_framePeriod: assert property (p_framePeriod) else $error("frame period wrong");
  a_rdHold: assert property (p_rdHold) else $error("read data moved without read");
  a_highPad: assert property (p_highPad) else $error("level high register pad bits set");
  a_video18: assert property (p_video18) else $error("video mode not the forwarded one");
  a_startBit: assert property (p_startBit) else $error("frame start bit low");
endmodule

bind lgt_link_gpio lgt_link_gpio_checker chk_u (.core_clk, .resetn, .regWrEn, .regRdEn, .regAddr, .regWrData,
  .regRdData, .fwdVideo18, .video18Mode, .bcData, .bcFrameStart, .localIoOut, .localIoOe, .audioRx);

// ### dv/lgt_serializer_model.sv
// Paired serializer model: free-running link clock, forward values, frame decoder.
// Bit time in core cycles is supplied by the bench.
`timescale 1ns/10ps
module lgt_serializer_model (
  // Core clock for decoding
  input logic core_clk,
  // Values to forward
  input logic twoLaneSet,
  input logic [3:0] fwdSet,
  input logic [3:0] fwdSecSet,
  input logic vid18Set,
  input int bitCyc,
  // Forward link
  output logic linkClk,
  output logic linkTwoLane,
  output logic [3:0] fwdGpio,
  output logic [3:0] fwdSecGpio,
  output logic fwdVideo18,
  // Back channel
  input logic bcData,
  input logic bcFrameStart,
  output logic [31:0] frame,
  output int frames
);
  int ph;
  int idx;
  logic [31:0] cur;
  initial begin
    {linkClk, linkTwoLane, fwdGpio, fwdSecGpio, fwdVideo18} = '0;
    frame = '0;
    frames = 0;
    idx = 32;
    forever #40 linkClk = ~linkClk;
  end
  // Forward values move on the falling edge so they are settled at the rise
  always @(negedge linkClk) {linkTwoLane, fwdGpio, fwdSecGpio, fwdVideo18} = {twoLaneSet, fwdSet, fwdSecSet, vid18Set};
  // Samples each bit mid-way, LSB first
  always @(posedge core_clk) begin
    if (bcFrameStart) begin
      ph = 1;
      idx = 0;
    end else if (idx < 32) begin
      if (ph == bitCyc / 2) cur[idx] = bcData;
      if (ph == bitCyc - 1) begin
        ph = 0;
        idx++;
      end else ph++;
      if (idx == 32) begin
        frame = cur;
        frames++;
      end
    end
  end
endmodule

// ### dv/test_lgt_link_gpio.sv
// Testbench of the link GPIO block: register tasks, pins, forward link, back channel.
// Inputs move 1 ns after the rising core clock edge.
`timescale 1ns/10ps
module test_lgt_link_gpio;
  import lgt_pkg::*;
  logic core_clk, resetn, regWrEn, regRdEn, strapSelectOne, twoLaneSet, vid18Set;
  logic [7:0] regAddr, regWrData, regRdData, rd;
  logic linkClk, linkTwoLane, fwdVideo18, video18Mode, bcData, bcFrameStart;
  logic [3:0] fwdGpio, fwdSecGpio, fwdSet, fwdSecSet, gpioIn, gpioOut, gpioOe, secGpioIn, secGpioOut;
  logic [3:0] secGpioOe, localIoIn, localIoOut, localIoOe, audioRx;
  logic [31:0] frame;
  int frames, bitCyc, bad_count, n_checks, gap;
  logic [7:0] rwRegs [8] = '{8'h34, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h23, 8'h43};
  logic [7:0] rates [3] = '{8'h00, 8'h40, 8'h50};
  int gaps [3] = '{1280, 640, 320};
  logic [2:0] modes [4] = '{3'h0, 3'h3, 3'h2, 3'h1};
  int nOnes [4] = '{4, 24, 20, 15};
  lgt_link_gpio dut_u (.core_clk, .resetn, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .linkClk,
    .linkTwoLane, .fwdGpio, .fwdSecGpio, .fwdVideo18, .video18Mode, .bcData, .bcFrameStart, .strapSelectOne,
    .gpioIn, .gpioOut, .gpioOe, .secGpioIn, .secGpioOut, .secGpioOe, .localIoIn, .localIoOut, .localIoOe, .audioRx);
  lgt_serializer_model pm_u (.core_clk, .twoLaneSet, .fwdSet, .fwdSecSet, .vid18Set, .bitCyc, .linkClk, .linkTwoLane,
    .fwdGpio, .fwdSecGpio, .fwdVideo18, .bcData, .bcFrameStart, .frame, .frames);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic waitCyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    waitCyc(1);
    {regWrEn, regAddr, regWrData} = {1'b1, a, d};
    waitCyc(1);
    regWrEn = 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a);
    waitCyc(1);
    {regRdEn, regAddr} = {1'b1, a};
    waitCyc(1);
    regRdEn = 1'b0;
    waitCyc(1);
    rd = regRdData;
  endtask
  task automatic waitFrames(input int n);
    int f;
    f = frames + n;
    wait (frames >= f);
  endtask
  task automatic waitStart;
    do waitCyc(1); while (bcFrameStart !== 1'b1);
  endtask
  task automatic doReset(input logic strap);
    waitCyc(1);
    {resetn, strapSelectOne} = {1'b0, strap};
    waitCyc(12);
    resetn = 1'b1;
    waitCyc(6);
  endtask
  task automatic testEnd(input string name);
    $display("Test %s done, mismatches so far %0d", name, bad_count);
  endtask
  task complete_run;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    complete_run;
  end
  initial begin
    {resetn, regWrEn, regRdEn, regAddr, regWrData, strapSelectOne} = '0;
    {twoLaneSet, vid18Set, fwdSet, fwdSecSet, gpioIn, secGpioIn, localIoIn} = '0;
    {bitCyc, bad_count, n_checks} = '0;
    bitCyc = 10;
    doReset(1'b0);
    foreach (rwRegs[i]) begin
      rdReg(rwRegs[i]);
      check(rd, 8'h00);
      wr(rwRegs[i], 8'hA5);
      rdReg(rwRegs[i]);
      check(rd, 8'hA5);
    end
    rdReg(8'h00);
    check(rd, 8'h00);
    wr(ADDR_LVL_HIGH, 8'hFF);
    rdReg(ADDR_LVL_HIGH);
    check(rd, 8'h00);
    testEnd("registers");
    doReset(1'b0);
    wr(ADDR_PORT_SEL, 8'h01);
    wr(ADDR_IO0_CFG, 8'h09);
    waitCyc(3);
    check({gpioOe[0], gpioOut[0]}, 2'b11);
    wr(ADDR_PORT_SEL, 8'h02);
    wr(ADDR_IO0_CFG, 8'h01);
    waitCyc(3);
    check({secGpioOe[0], secGpioOut[0], gpioOe[0], gpioOut[0]}, 4'hB);
    wr(ADDR_PORT_SEL, 8'h03);
    rdReg(ADDR_IO0_CFG);
    check(rd, 8'h01);
    wr(ADDR_IO0_CFG, 8'h05);
    wr(ADDR_PORT_SEL, 8'h01);
    rdReg(ADDR_IO0_CFG);
    check(rd, 8'h05);
    testEnd("port select");
    wr(ADDR_PORT_SEL, 8'h03);
    wr(ADDR_IO12_CFG, 8'h55);
    wr(ADDR_IO3_CFG, 8'h05);
    {fwdSet, fwdSecSet, twoLaneSet, vid18Set} = {4'hA, 4'h5, 1'b1, 1'b1};
    waitCyc(60);
    check({gpioOe, gpioOut, secGpioOe, secGpioOut, video18Mode}, {4'hF, 4'hA, 4'hF, 4'h5, 1'b1});
    {fwdSet, fwdSecSet} = {4'h5, 4'hA};
    waitCyc(60);
    check({gpioOut, secGpioOut}, {4'h5, 4'hA});
    twoLaneSet = 1'b0;
    waitCyc(60);
    check({secGpioOe, gpioOe}, {4'h0, 4'hF});
    testEnd("forward");
    wr(ADDR_IO0_CFG, 8'h03);
    wr(ADDR_IO12_CFG, 8'h33);
    wr(ADDR_IO3_CFG, 8'h03);
    wr(ADDR_LOC56_CFG, 8'h33);
    wr(ADDR_LOC78_CFG, 8'h33);
    {gpioIn, secGpioIn, localIoIn} = {4'h6, 4'h9, 4'hB};
    waitCyc(5);
    check({gpioOe, secGpioOe, localIoOe, audioRx}, 16'h0000);
    rdReg(ADDR_LVL_LOW);
    check(rd, 8'h69);
    rdReg(ADDR_LVL_HIGH);
    check(rd, 8'h01);
    wr(ADDR_PORT_SEL, 8'h01);
    rdReg(ADDR_LVL_LOW);
    check(rd, 8'h66);
    wr(ADDR_LOC56_CFG, 8'h19);
    waitCyc(4);
    check({localIoOe[1:0], localIoOut[1:0]}, 4'hD);
    wr(ADDR_LOC78_CFG, 8'h5F);
    waitCyc(4);
    check({localIoOe[3:2], audioRx}, {2'b00, 4'h8});
    testEnd("local");
    // 5 Mbps default stays usable with older partners
    foreach (rates[i]) begin
      wr(ADDR_BC_RATE, rates[i]);
      repeat (3) waitStart();
      gap = 0;
      do begin
        waitCyc(1);
        gap++;
      end while (bcFrameStart !== 1'b1);
      check(32'(gap), 32'(gaps[i]));
    end
    testEnd("rates");
    doReset(1'b1);
    rdReg(ADDR_BC_RATE);
    check(rd, 8'h10);
    wr(ADDR_PORT_SEL, 8'h03);
    wr(ADDR_IO0_CFG, 8'h03);
    wr(ADDR_IO12_CFG, 8'h33);
    wr(ADDR_IO3_CFG, 8'h03);
    {twoLaneSet, gpioIn, secGpioIn} = {1'b1, 4'h6, 4'hF};
    foreach (modes[i]) begin
      wr(ADDR_FAST_CH, {5'h00, modes[i]});
      waitFrames(3);
      check(frame, {modes[i], 24'((32'h1 << nOnes[i]) - 32'h1), 4'h6, 1'b1});
    end
    twoLaneSet = 1'b0;
    wr(ADDR_FAST_CH, 8'h00);
    waitFrames(3);
    check(frame, {3'h0, 24'h000000, 4'h6, 1'b1});
    testEnd("back channel");
    complete_run;
  end
endmodule

// ### rtl/lgt_bc_framer.sv
// Back-channel framer: samples the GPIO inputs and serialises one frame.
// Assumes the control side holds bitCycles stable and at least 1.
`timescale 1ns/10ps
module lgt_bc_framer
  import lgt_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Framer side of the carrier
  lgt_bc_if.tx bc
);

  logic [5:0] cycCnt_q;
  logic [4:0] bitIdx_q;
  logic [2:0] frameMode_q;
  logic [PAYLOAD_BITS-1:0] sampBuf_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic bitEn;
  logic frameEnd;
  logic [4:0] slotBase;

  assign bitEn = (cycCnt_q == bc.bitCycles - 6'h01);
  assign frameEnd = bitEn && (bitIdx_q == 5'(FRAME_BITS - 1));
  assign slotBase = 5'(PRI_BITS) + 5'(bitIdx_q * 5'(sampleWidth(frameMode_q)));

  ////////////////////////////////////////////////////////////////////////////
  // Bit-rate enable from the oscillator divider
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cycCnt_q <= 6'h00;
    end else if (bitEn || cycCnt_q >= bc.bitCycles) begin
      cycCnt_q <= 6'h00;
    end else begin
      cycCnt_q <= cycCnt_q + 6'h01;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bitIdx_q <= 5'h00;
    end else if (bitEn) begin
      bitIdx_q <= bitIdx_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampling: one slot per bit period at the start of the frame
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sampBuf_q <= '0;
      frameMode_q <= FAST_NORMAL;
    end else if (frameEnd) begin
      sampBuf_q <= '0;
      sampBuf_q[PRI_BITS-1:0] <= bc.priLevel;
      frameMode_q <= bc.fastMode;
    end else if (bitEn && bitIdx_q < sampleCount(frameMode_q)) begin
      for (int l = 0; l < PRI_BITS; l++) begin
        if (3'(l) < sampleWidth(frameMode_q)) begin
          sampBuf_q[slotBase + 5'(l)] <= bc.secLevel[l];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serialiser, LSB first: start bit, payload, mode
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= '0;
      bc.bcBit <= 1'b0;
      bc.bcFrameStart <= 1'b0;
    end else begin
      bc.bcFrameStart <= frameEnd;
      if (frameEnd) begin
        shift_q <= {frameMode_q, sampBuf_q, 1'b1};
        bc.bcBit <= 1'b1;
      end else if (bitEn) begin
        shift_q <= {1'b0, shift_q[FRAME_BITS-1:1]};
        bc.bcBit <= shift_q[1];
      end
    end
  end

endmodule

// ### rtl/lgt_bc_if.sv
// Carrier between the GPIO control logic and the back-channel framer.
// Both ends run on the core clock.
`timescale 1ns/10ps
interface lgt_bc_if;
  logic [5:0] bitCycles;
  logic [2:0] fastMode;
  logic [3:0] priLevel;
  logic [3:0] secLevel;
  logic bcBit;
  logic bcFrameStart;

  modport ctl (output bitCycles, output fastMode, output priLevel, output secLevel,
               input bcBit, input bcFrameStart);
  modport tx (input bitCycles, input fastMode, input priLevel, input secLevel,
              output bcBit, output bcFrameStart);
endinterface

// ### rtl/lgt_link_gpio.sv
// Link GPIO block of the deserializer: tunnelled, second-lane and local I/Os.
// Assumes pins and the forward link arrive asynchronously; registers are
// written by the control channel on the core clock.
`timescale 1ns/10ps
module lgt_link_gpio
  import lgt_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register access from the control channel
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Forward link
  input wire logic linkClk,
  input wire logic linkTwoLane,
  input wire logic [3:0] fwdGpio,
  input wire logic [3:0] fwdSecGpio,
  input wire logic fwdVideo18,
  output logic video18Mode,
  // Back channel
  output logic bcData,
  output logic bcFrameStart,
  // Strap
  input wire logic strapSelectOne,
  // Primary GPIO pins
  input wire logic [3:0] gpioIn,
  output logic [3:0] gpioOut,
  output logic [3:0] gpioOe,
  // Second-lane GPIO pins
  input wire logic [3:0] secGpioIn,
  output logic [3:0] secGpioOut,
  output logic [3:0] secGpioOe,
  // Local I/Os 5 to 8, shared with audio inputs
  input wire logic [3:0] localIoIn,
  output logic [3:0] localIoOut,
  output logic [3:0] localIoOe,
  output logic [3:0] audioRx
);

  localparam int SYNC_W = 24;

  lgt_bc_if bc();

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [3:0] gpioLvl;
  logic [3:0] secLvl;
  logic [3:0] locLvl;
  logic linkClkLvl;
  logic linkClkPrev_q;
  logic linkTwoLaneLvl;
  logic strapLvl;
  logic linkRise;
  logic [3:0] fwdGpio_q;
  logic [3:0] fwdSecGpio_q;
  logic video18_q;
  logic [7:0] io0Cfg_q [2];
  logic [7:0] io12Cfg_q [2];
  logic [7:0] io3Cfg_q [2];
  logic [7:0] loc56Cfg_q;
  logic [7:0] loc78Cfg_q;
  logic [7:0] bcRate_q;
  logic [7:0] portSel_q;
  logic [7:0] fastCh_q;
  logic [1:0] strapCnt_q;
  logic strapDone_q;
  logic [7:0] rdData_q;
  logic [3:0] gpioOut_q;
  logic [3:0] gpioOe_q;
  logic [3:0] secOut_q;
  logic [3:0] secOe_q;
  logic [3:0] locOut_q;
  logic [3:0] locOe_q;
  logic [3:0] audio_q;
  logic [5:0] bitCycles_q;
  logic [3:0] priLevel_q;
  logic [3:0] secLevel_q;
  logic [3:0] priCfg [2][4];
  logic [3:0] locCfg [4];
  logic rdPort;
  logic [7:0] lvlLow;
  logic [7:0] lvlHigh;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {strapSelectOne, linkTwoLane, fwdVideo18, fwdSecGpio, fwdGpio, linkClk,
                  localIoIn, secGpioIn, gpioIn};
      sync2_q <= sync1_q;
    end
  end

  assign gpioLvl = sync2_q[3:0];
  assign secLvl = sync2_q[7:4];
  assign locLvl = sync2_q[11:8];
  assign linkClkLvl = sync2_q[12];
  assign linkTwoLaneLvl = sync2_q[22];
  assign strapLvl = sync2_q[23];
  assign linkRise = linkClkLvl && !linkClkPrev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Forward-channel capture on link clock edges
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      linkClkPrev_q <= 1'b0;
      fwdGpio_q <= 4'h0;
      fwdSecGpio_q <= 4'h0;
      video18_q <= 1'b0;
    end else begin
      linkClkPrev_q <= linkClkLvl;
      if (linkRise) begin
        fwdGpio_q <= sync2_q[16:13];
        fwdSecGpio_q <= sync2_q[20:17];
        video18_q <= sync2_q[21];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture a few cycles after reset release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strapCnt_q <= 2'h0;
      strapDone_q <= 1'b0;
    end else if (!strapDone_q) begin
      strapCnt_q <= strapCnt_q + 2'h1;
      strapDone_q <= (strapCnt_q == STRAP_WAIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; local and remote accesses share this port
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < 2; p++) begin
        io0Cfg_q[p] <= RST_CFG;
        io12Cfg_q[p] <= RST_CFG;
        io3Cfg_q[p] <= RST_CFG;
      end
      loc56Cfg_q <= RST_CFG;
      loc78Cfg_q <= RST_CFG;
      bcRate_q <= RST_BC_RATE;
      portSel_q <= RST_PORT_SEL;
      fastCh_q <= RST_FAST_CH;
    end else begin
      if (!strapDone_q && strapCnt_q == STRAP_WAIT) begin
        bcRate_q[HIGH_SPEED_BIT] <= strapLvl;
      end
      if (regWrEn) begin
        for (int p = 0; p < 2; p++) begin
          if (portSel_q[p]) begin
            unique case (regAddr)
              ADDR_IO0_CFG: io0Cfg_q[p] <= regWrData;
              ADDR_IO12_CFG: io12Cfg_q[p] <= regWrData;
              ADDR_IO3_CFG: io3Cfg_q[p] <= regWrData;
              default: ;
            endcase
          end
        end
        unique case (regAddr)
          ADDR_LOC56_CFG: loc56Cfg_q <= regWrData;
          ADDR_LOC78_CFG: loc78Cfg_q <= regWrData;
          ADDR_BC_RATE: bcRate_q <= regWrData;
          ADDR_PORT_SEL: portSel_q <= regWrData;
          ADDR_FAST_CH: fastCh_q <= regWrData;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin configuration fields
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      priCfg[p][0] = io0Cfg_q[p][3:0];
      priCfg[p][1] = io12Cfg_q[p][3:0];
      priCfg[p][2] = io12Cfg_q[p][7:4];
      priCfg[p][3] = io3Cfg_q[p][3:0];
    end
    locCfg[0] = loc56Cfg_q[3:0];
    locCfg[1] = loc56Cfg_q[7:4];
    locCfg[2] = loc78Cfg_q[3:0];
    locCfg[3] = loc78Cfg_q[7:4];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gpioOut_q <= 4'h0;
      gpioOe_q <= 4'h0;
      secOut_q <= 4'h0;
      secOe_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        unique case (ioDecode(priCfg[0][i]))
          IO_FWD_OUT: {gpioOe_q[i], gpioOut_q[i]} <= {1'b1, fwdGpio_q[i]};
          IO_LOW: {gpioOe_q[i], gpioOut_q[i]} <= 2'h2;
          IO_HIGH: {gpioOe_q[i], gpioOut_q[i]} <= 2'h3;
          default: {gpioOe_q[i], gpioOut_q[i]} <= 2'h0;
        endcase
        unique case (ioDecode(priCfg[1][i]))
          IO_FWD_OUT: {secOe_q[i], secOut_q[i]} <= {linkTwoLaneLvl, fwdSecGpio_q[i]};
          IO_LOW: {secOe_q[i], secOut_q[i]} <= 2'h2;
          IO_HIGH: {secOe_q[i], secOut_q[i]} <= 2'h3;
          default: {secOe_q[i], secOut_q[i]} <= 2'h0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      locOut_q <= 4'h0;
      locOe_q <= 4'h0;
      audio_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        unique case (ioDecode(locCfg[i]))
          IO_LOW: {locOe_q[i], locOut_q[i]} <= 2'h2;
          IO_HIGH: {locOe_q[i], locOut_q[i]} <= 2'h3;
          default: {locOe_q[i], locOut_q[i]} <= 2'h0;
        endcase
        // Audio is blocked only while the local code selects output low, output high or input
        audio_q[i] <= (ioDecode(locCfg[i]) inside {IO_LOW, IO_HIGH, IO_INPUT}) ? 1'b0 : locLvl[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Back-channel feed; local I/Os never enter it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bitCycles_q <= 6'(BC_BIT_CYC) * 6'(DIV_SLOW);
      priLevel_q <= 4'h0;
      secLevel_q <= 4'h0;
    end else begin
      if (bcRate_q[HIGH_SPEED_BIT]) begin
        bitCycles_q <= 6'(BC_BIT_CYC) * 6'(DIV_FAST);
      end else if (bcRate_q[RATE_SEL_BIT]) begin
        bitCycles_q <= 6'(BC_BIT_CYC) * 6'(DIV_MID);
      end else begin
        bitCycles_q <= 6'(BC_BIT_CYC) * 6'(DIV_SLOW);
      end
      for (int i = 0; i < 4; i++) begin
        priLevel_q[i] <= (ioDecode(priCfg[0][i]) == IO_INPUT) && gpioLvl[i];
        secLevel_q[i] <= linkTwoLaneLvl && (ioDecode(priCfg[1][i]) == IO_INPUT) && secLvl[i];
      end
    end
  end

  assign bc.bitCycles = bitCycles_q;
  assign bc.fastMode = fastCh_q[2:0];
  assign bc.priLevel = priLevel_q;
  assign bc.secLevel = secLevel_q;

  lgt_bc_framer u_framer (
    .core_clk(core_clk),
    .resetn(resetn),
    .bc(bc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  assign rdPort = portSel_q[SECOND_PICK_BIT];
  assign lvlLow = {locLvl[2:0], 1'b0, rdPort ? secLvl : gpioLvl};
  assign lvlHigh = {7'h00, locLvl[3]};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= 8'h00;
    end else if (regRdEn) begin
      unique case (regAddr)
        ADDR_IO0_CFG: rdData_q <= io0Cfg_q[rdPort];
        ADDR_IO12_CFG: rdData_q <= io12Cfg_q[rdPort];
        ADDR_IO3_CFG: rdData_q <= io3Cfg_q[rdPort];
        ADDR_LOC56_CFG: rdData_q <= loc56Cfg_q;
        ADDR_LOC78_CFG: rdData_q <= loc78Cfg_q;
        ADDR_BC_RATE: rdData_q <= bcRate_q;
        ADDR_PORT_SEL: rdData_q <= portSel_q;
        ADDR_FAST_CH: rdData_q <= fastCh_q;
        ADDR_LVL_LOW: rdData_q <= lvlLow;
        ADDR_LVL_HIGH: rdData_q <= lvlHigh;
        default: rdData_q <= 8'h00;
      endcase
    end
  end

  assign regRdData = rdData_q;
  assign video18Mode = video18_q;
  assign bcData = bc.bcBit;
  assign bcFrameStart = bc.bcFrameStart;
  assign gpioOut = gpioOut_q;
  assign gpioOe = gpioOe_q;
  assign secGpioOut = secOut_q;
  assign secGpioOe = secOe_q;
  assign localIoOut = locOut_q;
  assign localIoOe = locOe_q;
  assign audioRx = audio_q;

endmodule

// ### rtl/lgt_pkg.sv
// Constants, register map and the I/O mode decoder for the link GPIO block.
// Assumes a 200 MHz core clock; the back-channel oscillator is derived from it.
package lgt_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_IO0_CFG = 8'h1D;
  localparam logic [7:0] ADDR_IO12_CFG = 8'h1E;
  localparam logic [7:0] ADDR_IO3_CFG = 8'h1F;
  localparam logic [7:0] ADDR_LOC56_CFG = 8'h20;
  localparam logic [7:0] ADDR_LOC78_CFG = 8'h21;
  localparam logic [7:0] ADDR_BC_RATE = 8'h23;
  localparam logic [7:0] ADDR_PORT_SEL = 8'h34;
  localparam logic [7:0] ADDR_FAST_CH = 8'h43;
  localparam logic [7:0] ADDR_LVL_LOW = 8'h6E;
  localparam logic [7:0] ADDR_LVL_HIGH = 8'h6F;

  // Reset values
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_BC_RATE = 8'h00;
  localparam logic [7:0] RST_PORT_SEL = 8'h00;
  localparam logic [7:0] RST_FAST_CH = 8'h00;

  // Field positions
  localparam int RATE_SEL_BIT = 6;
  localparam int HIGH_SPEED_BIT = 4;
  localparam int FIRST_PICK_BIT = 0;
  localparam int SECOND_PICK_BIT = 1;
  localparam int LVL_LOC_LSB = 5;

  // Pin configuration codes
  localparam logic [3:0] CODE_FWD_OUT = 4'h5;
  localparam logic [3:0] CODE_INPUT = 4'h3;
  localparam logic [3:0] CODE_OUT_LOW = 4'h1;
  localparam logic [3:0] CODE_OUT_HIGH = 4'h9;

  // Fast channel modes and their sample counts
  localparam logic [2:0] FAST_NORMAL = 3'h0;
  localparam logic [2:0] FAST_FOUR_PIN = 3'h3;
  localparam logic [2:0] FAST_TWO_PIN = 3'h2;
  localparam logic [2:0] FAST_ONE_PIN = 3'h1;
  localparam logic [4:0] SAMPLES_NORMAL = 5'h01;
  localparam logic [4:0] SAMPLES_FOUR_PIN = 5'h06;
  localparam logic [4:0] SAMPLES_TWO_PIN = 5'h0A;
  localparam logic [4:0] SAMPLES_ONE_PIN = 5'h0F;

  // Back-channel timing: 20 Mbps bit at divide-by-1
  localparam int CLK_PERIOD_NS = 5;
  localparam int BC_BIT_NS = 50;
  localparam int BC_BIT_CYC = (BC_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] DIV_FAST = 3'h1;
  localparam logic [2:0] DIV_MID = 3'h2;
  localparam logic [2:0] DIV_SLOW = 3'h4;

  // Back-channel frame: start bit, 28 payload bits, 3 mode bits
  localparam int FRAME_BITS = 32;
  localparam int PAYLOAD_BITS = 28;
  localparam int PRI_BITS = 4;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum logic [2:0] {IO_OFF, IO_FWD_OUT, IO_INPUT, IO_LOW, IO_HIGH} lgt_iomode_e;

  function automatic lgt_iomode_e ioDecode(input logic [3:0] code);
    unique case (code)
      CODE_FWD_OUT: ioDecode = IO_FWD_OUT;
      CODE_INPUT: ioDecode = IO_INPUT;
      CODE_OUT_LOW: ioDecode = IO_LOW;
      CODE_OUT_HIGH: ioDecode = IO_HIGH;
      default: ioDecode = IO_OFF;
    endcase
  endfunction

  function automatic logic [4:0] sampleCount(input logic [2:0] mode);
    unique case (mode)
      FAST_FOUR_PIN: sampleCount = SAMPLES_FOUR_PIN;
      FAST_TWO_PIN: sampleCount = SAMPLES_TWO_PIN;
      FAST_ONE_PIN: sampleCount = SAMPLES_ONE_PIN;
      default: sampleCount = SAMPLES_NORMAL;
    endcase
  endfunction

  function automatic logic [2:0] sampleWidth(input logic [2:0] mode);
    unique case (mode)
      FAST_TWO_PIN: sampleWidth = 3'h2;
      FAST_ONE_PIN: sampleWidth = 3'h1;
      default: sampleWidth = 3'h4;
    endcase
  endfunction

endpackage
